// ### verilog/flash_seq_defines.svh
// constants for the flash page erase / row program sequencer
// assumes a 250 MHz bus clock and a 32-bit classic wishbone register port
// What this block does
// - erase-select with whole-array-select clear arms a single page erase.
// - page erase acts on exactly one aligned 128-byte page.
// - a write into the target page after the protect-register read latches its address; data is dropped.
// - array readable again only after about 1 us recovery.
// - programming works on aligned 64-byte rows.
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define CTRL_OFFSET 32'h0000_0000
`define PROT_OFFSET 32'h0000_0004
`define STAT_OFFSET 32'h0000_0008
`define ADDR_OFFSET 32'h0000_000c
`define ARRAY_BASE_HI 16'h0001

`define CTRL_PGM_BIT 0
`define CTRL_ERASE_BIT 1
`define CTRL_WHOLE_BIT 2
`define CTRL_HV_BIT 3
`define CTRL_LONG_BIT 4
`define CTRL_RESET 8'h00
`define PROT_RESET 8'h00

`define STAT_ARMED_BIT 0
`define STAT_LATCHED_BIT 1
`define STAT_HV_BIT 2
`define STAT_READY_BIT 3
`define STAT_ERR_BIT 4
`define STAT_SETUP_BIT 5
`define STAT_ERASE_BIT 6
`define STAT_HOLD_BIT 7

`define PAGE_LSB 7
`define ROW_LSB 6

`define CLK_PERIOD_NS 4
`define SETUP_DELAY_NS 10000
`define HOLD_DELAY_NS 5000
`define RECOVERY_DELAY_NS 1000
`define ERASE_SHORT_NS 1000000
`define ERASE_LONG_NS 4000000
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/flash_seq_pkg.sv
// types shared by the flash sequencer files
// assumes flash_seq_defines.svh is on the include path
`default_nettype none
package flash_seq_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_PROT_READ,
    SEQ_LATCHED,
    SEQ_HV_ON,
    SEQ_HOLD,
    SEQ_RECOVER
  } seq_state_t;

  typedef struct packed {
    logic hv;
    logic erase_page;
    logic erase_all;
    logic program_row;
    logic [15:0] addr;
  } array_cmd_t;

endpackage
`default_nettype wire

// ### verilog/flash_seq_rst_sync.sv
// reset release synchroniser
// assumes an active-low asynchronous reset input
`timescale 1ns/1ps
`default_nettype none
module flash_seq_rst_sync (
  input wire logic clk_in,    // bus clock
  input wire logic resetn_in, // raw reset, active low
  output logic resetn_out     // synchronised reset, active low
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb begin
    sync_d = {sync_q[0], 1'b1};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_q <= 2'b00;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign resetn_out = sync_q[1];
endmodule
`default_nettype wire

// ### verilog/flash_seq_timer.sv
// elapsed-time monitor: counts while run is high, clears when low
// assumes limit is at least one and stable while run is high
`timescale 1ns/1ps
`default_nettype none
module flash_seq_timer (
  input wire logic clk_in,        // bus clock
  input wire logic rst_n_in,      // synchronised reset, active low
  input wire logic ce_in,         // clock enable
  input wire logic run_in,        // count while high
  input wire logic [19:0] limit_in, // cycles to reach
  output logic done_out           // limit reached, registered level
);
  logic [19:0] count_q;
  logic [19:0] count_d;
  logic done_q;
  logic done_d;

  always_comb begin
    count_d = 20'h0_0000;
    if (run_in) begin
      // saturate so a long stall never wraps back to not-done
      count_d = (count_q >= limit_in) ? count_q : count_q + 20'h0_0001;
    end
    done_d = run_in && (count_d >= limit_in);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 20'h0_0000;
      done_q <= 1'b0;
    end else if (ce_in) begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;
endmodule
`default_nettype wire

// ### verilog/flash_page_erase_row_program.sv
// flash page erase / row program sequencer with a wishbone register port
// assumes classic single-cycle wishbone masters and a flash array that obeys
// array_cmd_out; the array data path itself lives outside this block
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_page_erase_row_program #(
  parameter logic [19:0] ERASE_SHORT_CYC = 20'(`NS_TO_CYC(`ERASE_SHORT_NS)),
  parameter logic [19:0] ERASE_LONG_CYC = 20'(`NS_TO_CYC(`ERASE_LONG_NS))
) (
  input wire logic clk_in,                        // 250 MHz bus clock
  input wire logic resetn_in,                     // async reset, active low
  input wire logic ce_in,                         // clock enable, freezes all state except the reset synchroniser
  input wire logic wb_cyc_in,                     // wishbone cycle
  input wire logic wb_stb_in,                     // wishbone strobe
  input wire logic wb_we_in,                      // wishbone write enable
  input wire logic [3:0] wb_sel_in,               // wishbone byte selects
  input wire logic [31:0] wb_adr_in,              // wishbone byte address
  input wire logic [31:0] wb_dat_in,              // wishbone write data
  output logic wb_ack_out,                        // wishbone acknowledge
  output logic [31:0] wb_dat_out,                 // wishbone read data
  output flash_seq_pkg::array_cmd_t array_cmd_out, // command to the flash array
  output logic array_ready_out                    // array free for normal reads
);
  import flash_seq_pkg::*;

  localparam logic [19:0] SETUP_CYC = 20'(`NS_TO_CYC(`SETUP_DELAY_NS));
  localparam logic [19:0] HOLD_CYC = 20'(`NS_TO_CYC(`HOLD_DELAY_NS));
  localparam logic [19:0] RECOVERY_CYC = 20'(`NS_TO_CYC(`RECOVERY_DELAY_NS));

  logic rst_n;

  flash_seq_rst_sync u_rst_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .resetn_out(rst_n)
  );

  // ---------------- bus decode ----------------
  logic req;
  logic in_array;
  logic hit_ctrl;
  logic hit_prot;
  logic hit_stat;
  logic hit_addr;
  logic wr_ctrl;
  logic wr_prot;
  logic wr_stat;
  logic rd_prot;
  logic arr_wr;
  logic arr_rd;

  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  // one access per request: the request is taken the cycle before ack is high and ignored while ack is high
  assign req = wb_cyc_in && wb_stb_in && !ack_q;
  assign in_array = (wb_adr_in[31:16] == `ARRAY_BASE_HI);
  assign hit_ctrl = (wb_adr_in == `CTRL_OFFSET);
  assign hit_prot = (wb_adr_in == `PROT_OFFSET);
  assign hit_stat = (wb_adr_in == `STAT_OFFSET);
  assign hit_addr = (wb_adr_in == `ADDR_OFFSET);
  assign wr_ctrl = req && wb_we_in && hit_ctrl && wb_sel_in[0];
  assign wr_prot = req && wb_we_in && hit_prot && wb_sel_in[0];
  assign wr_stat = req && wb_we_in && hit_stat && wb_sel_in[0];
  assign rd_prot = req && !wb_we_in && hit_prot;
  assign arr_wr = req && wb_we_in && in_array;
  assign arr_rd = req && !wb_we_in && in_array;

  // ---------------- registers and sequence ----------------
  seq_state_t state_q;
  seq_state_t state_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic op_erase_q;
  logic op_erase_d;
  logic op_whole_q;
  logic op_whole_d;
  logic err_q;
  logic err_d;
  array_cmd_t cmd_q;
  array_cmd_t cmd_d;
  logic ready_q;
  logic ready_d;

  logic setup_met;
  logic erase_met;
  logic hold_met;
  logic recover_done;
  logic [19:0] erase_limit;
  logic [7:0] ctrl_new;
  logic err_set;
  logic op_set;
  logic new_op;
  logic new_hv;

  assign ctrl_new = wr_ctrl ? wb_dat_in[7:0] : ctrl_q;
  assign op_set = ctrl_q[`CTRL_ERASE_BIT] || ctrl_q[`CTRL_PGM_BIT];
  assign new_op = ctrl_new[`CTRL_ERASE_BIT] || ctrl_new[`CTRL_PGM_BIT];
  assign new_hv = ctrl_new[`CTRL_HV_BIT];
  // long or short erase is software's endurance choice
  assign erase_limit = ctrl_q[`CTRL_LONG_BIT] ? ERASE_LONG_CYC : ERASE_SHORT_CYC;

  flash_seq_timer u_setup_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .run_in(state_q == SEQ_LATCHED),
    .limit_in(SETUP_CYC),
    .done_out(setup_met)
  );

  flash_seq_timer u_erase_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .run_in(state_q == SEQ_HV_ON),
    .limit_in(erase_limit),
    .done_out(erase_met)
  );

  flash_seq_timer u_hold_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .run_in(state_q == SEQ_HOLD),
    .limit_in(HOLD_CYC),
    .done_out(hold_met)
  );

  flash_seq_timer u_recover_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .run_in(state_q == SEQ_RECOVER),
    .limit_in(RECOVERY_CYC),
    .done_out(recover_done)
  );

  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_new;
    prot_d = wr_prot ? wb_dat_in[7:0] : prot_q;
    addr_d = addr_q;
    op_erase_d = op_erase_q;
    op_whole_d = op_whole_q;
    err_set = 1'b0;
    // any touch of the array space once the address is latched sets the error flag; the sequence carries on
    if ((arr_rd || arr_wr) && state_q != SEQ_IDLE && state_q != SEQ_ARMED
        && state_q != SEQ_PROT_READ) begin
      err_set = 1'b1;
    end
    case (state_q)
      SEQ_IDLE: begin
        if (new_op) begin
          op_erase_d = ctrl_new[`CTRL_ERASE_BIT];
          op_whole_d = ctrl_new[`CTRL_WHOLE_BIT];
          state_d = SEQ_ARMED;
        end
        if (new_hv) begin
          err_set = 1'b1;
        end
      end
      SEQ_ARMED: begin
        if (!new_op) begin
          state_d = SEQ_IDLE;
        end else if (rd_prot) begin
          state_d = SEQ_PROT_READ;
        end else if (arr_wr || new_hv) begin
          err_set = 1'b1;
        end
      end
      SEQ_PROT_READ: begin
        if (!new_op) begin
          state_d = SEQ_IDLE;
        end else if (arr_wr) begin
          // the written data is dropped, only the address selects the target
          addr_d = wb_adr_in[15:0];
          state_d = SEQ_LATCHED;
        end else if (new_hv) begin
          err_set = 1'b1;
        end
      end
      SEQ_LATCHED: begin
        if (!new_op) begin
          state_d = SEQ_IDLE;
        end else if (new_hv) begin
          err_set = !setup_met;
          state_d = SEQ_HV_ON;
        end
      end
      SEQ_HV_ON: begin
        if (!new_hv) begin
          err_set = 1'b1;
          state_d = SEQ_RECOVER;
        end else if (!new_op) begin
          err_set = op_erase_q && !erase_met;
          state_d = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!new_hv) begin
          err_set = !hold_met;
          state_d = SEQ_RECOVER;
        end
      end
      SEQ_RECOVER: begin
        if (recover_done) begin
          state_d = SEQ_IDLE;
        end
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
    // hardware set wins over a software clear in the same cycle
    err_d = err_set || (err_q && !(wr_stat && wb_dat_in[`STAT_ERR_BIT]));

    // high voltage while a latched operation runs and on through the hold state after it
    cmd_d.hv = (state_d == SEQ_HV_ON) || (state_d == SEQ_HOLD);
    cmd_d.erase_page = (state_d == SEQ_HV_ON) && op_erase_d && !op_whole_d;
    cmd_d.erase_all = (state_d == SEQ_HV_ON) && op_erase_d && op_whole_d;
    cmd_d.program_row = (state_d == SEQ_HV_ON) && !op_erase_d;
    if (op_erase_d) begin
      cmd_d.addr = {addr_d[15:`PAGE_LSB], 7'h00};
    end else begin
      cmd_d.addr = {addr_d[15:`ROW_LSB], 6'h00};
    end
    ready_d = (state_d == SEQ_IDLE) || (state_d == SEQ_ARMED)
              || (state_d == SEQ_PROT_READ);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SEQ_IDLE;
      ctrl_q <= `CTRL_RESET;
      prot_q <= `PROT_RESET;
      addr_q <= 16'h0000;
      op_erase_q <= 1'b0;
      op_whole_q <= 1'b0;
      err_q <= 1'b0;
      cmd_q <= '0;
      ready_q <= 1'b1;
    end else if (ce_in) begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      prot_q <= prot_d;
      addr_q <= addr_d;
      op_erase_q <= op_erase_d;
      op_whole_q <= op_whole_d;
      err_q <= err_d;
      cmd_q <= cmd_d;
      ready_q <= ready_d;
    end
  end

  // ---------------- bus answer ----------------
  always_comb begin
    ack_d = req;
    rdat_d = rdat_q;
    if (req && !wb_we_in) begin
      rdat_d = 32'h0000_0000;
      if (hit_ctrl) begin
        rdat_d[7:0] = ctrl_q;
      end else if (hit_prot) begin
        rdat_d[7:0] = prot_q;
      end else if (hit_stat) begin
        rdat_d[`STAT_ARMED_BIT] = op_set && (state_q != SEQ_IDLE);
        rdat_d[`STAT_LATCHED_BIT] = (state_q == SEQ_LATCHED) || cmd_q.hv;
        rdat_d[`STAT_HV_BIT] = cmd_q.hv;
        rdat_d[`STAT_READY_BIT] = ready_q;
        rdat_d[`STAT_ERR_BIT] = err_q;
        rdat_d[`STAT_SETUP_BIT] = setup_met;
        rdat_d[`STAT_ERASE_BIT] = erase_met;
        rdat_d[`STAT_HOLD_BIT] = hold_met;
      end else if (hit_addr) begin
        rdat_d[15:0] = addr_q;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_in) begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
  assign array_cmd_out = cmd_q;
  assign array_ready_out = ready_q;
endmodule
`default_nettype wire

// ### dv/flash_seq_props.sv
// port-level checks for the flash page erase / row program sequencer
// assumes ce_in high whenever a timed relation below must hold
`timescale 1ns/1ps
`default_nettype none
module flash_seq_props (
  input wire logic clk_in, // bus clock
  input wire logic resetn_in, // raw reset, active low
  input wire logic ce_in, // clock enable
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_ack_out, // wishbone acknowledge
  input wire logic [31:0] wb_dat_out, // read data
  input wire flash_seq_pkg::array_cmd_t array_cmd_out, // array command
  input wire logic array_ready_out // array readable
);
  logic [9:0] off_q;
  // cycles since high voltage went away, saturating
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) off_q <= 10'h3ff;
    else if (array_cmd_out.hv) off_q <= 10'h000;
    else if (off_q != 10'h3ff) off_q <= off_q + 10'h001;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
  endsequence
  logic op_any;
  // plain signal so the edge functions see an expression, not a sequence
  assign op_any = array_cmd_out.erase_page || array_cmd_out.erase_all
                  || array_cmd_out.program_row;
  sequence op_s;
    op_any;
  endsequence
  a_ack_answers: assert property (req_s |=> wb_ack_out)
    else $error("request not acknowledged next cycle");
  a_ack_one_cycle: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_in && wb_stb_in) && ce_in |=> !wb_ack_out)
    else $error("ack without request");
  a_dat_holds: assert property ($changed(wb_dat_out) |-> wb_ack_out)
    else $error("read data changed outside ack");
  a_hv_with_op: assert property ($rose(array_cmd_out.hv) |-> op_s)
    else $error("high voltage without armed operation");
  a_page_aligned: assert property (array_cmd_out.erase_page |-> array_cmd_out.addr[6:0] == 7'h00)
    else $error("erase address not page aligned");
  a_row_aligned: assert property (array_cmd_out.program_row |-> array_cmd_out.addr[5:0] == 6'h00)
    else $error("program address not row aligned");
  a_busy_no_read: assert property (array_cmd_out.hv |-> !array_ready_out)
    else $error("array ready while high voltage applied");
  a_recover_time: assert property ($rose(array_ready_out) |-> off_q >= 10'd240)
    else $error("array ready before recovery time");
  a_op_under_hv: assert property ($rose(op_any) |-> array_cmd_out.hv)
    else $error("operation applied without high voltage");
endmodule
bind flash_page_erase_row_program flash_seq_props props_u (
  .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
  .array_cmd_out(array_cmd_out), .array_ready_out(array_ready_out));
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the flash sequencer: erase, program, whole erase, faults
// assumes sim erase lengths of 40 and 80 cycles and a 4 ns clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_seq_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic ce = 1'b1;
  logic [15:0] exp_addr [$];
  logic [31:0] adr = 32'h0, dat = 32'h0;
  logic wb_ack_out;
  logic [31:0] wb_dat_out;
  array_cmd_t array_cmd_out;
  logic array_ready_out;
  int failures = 0, n_tests = 0, seed = 19;
  logic [31:0] r;
  logic [15:0] a;
  logic [7:0] ctl [3];
  logic [15:0] msk [3];
  flash_page_erase_row_program #(.ERASE_SHORT_CYC(20'd40), .ERASE_LONG_CYC(20'd80)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_sel_in(sel), .wb_adr_in(adr), .wb_dat_in(dat),
    .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .array_cmd_out(array_cmd_out),
    .array_ready_out(array_ready_out));
  initial forever #2 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] ad, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rdv);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= d; sel <= s;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rdv = wb_dat_out;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1);
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, ad, d, 4'hf, x);
  endtask
  task automatic rd(input logic [31:0] ad, output logic [31:0] v);
    wb(1'b0, ad, 32'h0, 4'hf, v);
  endtask
  initial begin
    #160000;
    failures++;
    results();
  end
  initial begin
    ctl = '{8'h02, 8'h11, 8'h16};
    msk = '{16'hff80, 16'hffc0, 16'h0000};
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(array_cmd_out, '0);
    chk(array_ready_out, 1'b1);
    rd(32'h0, r); chk(r, 32'h0);
    rd(32'h4, r); chk(r, 32'h0);
    rd(32'h8, r); chk(r, 32'h8);
    rd(32'h40, r); chk(r, 32'h0);
    $display("test reset values done");
    a = 16'($random(seed));
    wr(32'h4, {24'h0, a[7:0]});
    wb(1'b1, 32'h4, 32'h0, 4'he, r);
    rd(32'h4, r); chk(r, {24'h0, a[7:0]});
    $display("test protect register done");
    for (int m = 0; m < 3; m++) begin
      a = 16'($random(seed));
      wr(32'h0, {24'h0, ctl[m]});
      rd(32'h4, r);
      exp_addr.push_back(a);
      wr({16'h0001, a}, 32'($random(seed)));
      rd(32'hc, r); chk(r, {16'h0, exp_addr[0]});
      chk(array_cmd_out.hv, 1'b0);
      repeat (2510) @(posedge clk_in);
      rd(32'h8, r); chk(r[7:0], 8'h23);
      wr(32'h0, {24'h0, ctl[m] | 8'h08});
      repeat (2) @(posedge clk_in);
      chk({array_cmd_out.hv, array_cmd_out.erase_page, array_cmd_out.erase_all,
           array_cmd_out.program_row}, {1'b1, m == 0, m == 2, m == 1});
      if (m < 2) chk(array_cmd_out.addr, exp_addr[0] & msk[m]);
      exp_addr.delete(0);
      chk(array_ready_out, 1'b0);
      repeat (90) @(posedge clk_in);
      wr(32'h0, {24'h0, (ctl[m] & 8'h10) | 8'h08});
      repeat (2) @(posedge clk_in);
      chk({array_cmd_out.hv, array_cmd_out.erase_page, array_cmd_out.program_row},
          3'b100);
      repeat (1260) @(posedge clk_in);
      wr(32'h0, 32'h0);
      // a frozen clock enable stretches recovery by the frozen cycles
      ce <= 1'b0;
      repeat (20) @(posedge clk_in);
      ce <= 1'b1;
      repeat (80) @(posedge clk_in);
      chk(array_ready_out, 1'b0);
      repeat (160) @(posedge clk_in);
      chk(array_ready_out, 1'b0);
      repeat (20) @(posedge clk_in);
      chk(array_ready_out, 1'b1);
      rd(32'h8, r); chk(r[4:3], 2'b01);
      $display("test sequence mode %0d done", m);
    end
    wr(32'h0, 32'h08);
    repeat (2) @(posedge clk_in);
    chk(array_cmd_out.hv, 1'b0);
    rd(32'h8, r); chk(r[4], 1'b1);
    // the flag re-arms every cycle while the stray enable bit stays set
    wr(32'h0, 32'h0);
    wr(32'h8, 32'h10);
    rd(32'h8, r); chk(r[4], 1'b0);
    wr(32'h0, 32'h02);
    wr(32'h0001_0000, 32'h0);
    rd(32'h8, r); chk(r[4], 1'b1);
    wr(32'h0, 32'h0);
    wr(32'h8, 32'h10);
    // a stray array read between steps flags an error but leaves a latched sequence latched
    wr(32'h0, 32'h02);
    rd(32'h4, r);
    wr(32'h0001_0080, 32'h0);
    rd(32'h0001_fffc, r);
    rd(32'h8, r); chk(r[4:0], 5'h13);
    wr(32'h0, 32'h0);
    wr(32'h8, 32'h10);
    rd(32'h8, r); chk(r[4], 1'b0);
    $display("test fault handling done");
    results();
  end
endmodule
`default_nettype wire
